// File: rtl/pesc_pkg.sv
package pesc_pkg;
  // 0x0E2 is not word-aligned, so the printed offsets are register indices.
  localparam logic [11:0] WEC_INDEX      = 12'h0E2;
  localparam logic [11:0] CS_INDEX       = 12'h0E4;
  localparam int          ADDR_W         = 14;
  localparam logic [13:0] WEC_ADDR       = 14'(WEC_INDEX * 4);
  localparam logic [13:0] CS_ADDR        = 14'(CS_INDEX * 4);
  localparam logic [15:0] WEC_RESET      = 16'h0000;
  localparam logic [15:0] WEC_SAT        = 16'hFFFF;
  localparam logic [15:0] ONE16          = 16'h0001;
  localparam int          BIT_HW_EEE     = 14;
  localparam int          BIT_TX_LPI_LH  = 13;
  localparam int          BIT_TX_LPI     = 12;
  localparam int          BIT_RX_LPI_LH  = 11;
  localparam int          BIT_RX_LPI     = 10;
  localparam int          BIT_NP_LOC_ABL = 6;
  localparam int          BIT_NP_LOC     = 5;
  localparam int          BIT_PD_FAULT   = 4;
  localparam int          BIT_LP_NP_ABL  = 3;
  localparam int          BIT_NP_ABL     = 2;
  localparam int          BIT_PAGE_RX    = 1;
  localparam int          BIT_LP_AN_ABL  = 0;
  localparam int          BIT_RSVD15     = 15;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;
  // Wake-up limit in ns, and its cycle count at the 200 MHz clock (informative).
  localparam real         WAKE_LIMIT_NS  = 20500.0;
  localparam real         CLK_PERIOD_NS  = 5.0;
  localparam int          WAKE_LIMIT_CYC = int'(WAKE_LIMIT_NS / CLK_PERIOD_NS);
endpackage : pesc_pkg

// File: rtl/pesc_regs.sv
`timescale 1ns/1ps
module pesc_regs
  import pesc_pkg::*;
(
  // Clock and reset
  input  wire logic              mclk_in,
  input  wire logic              rst_n_in,
  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr_in,
  input  wire logic              s_axi_awvalid_in,
  output logic                   s_axi_awready_out,
  // AXI4-Lite write data
  input  wire logic [31:0]       s_axi_wdata_in,
  input  wire logic [3:0]        s_axi_wstrb_in,
  input  wire logic              s_axi_wvalid_in,
  output logic                   s_axi_wready_out,
  // AXI4-Lite write response
  output logic [1:0]             s_axi_bresp_out,
  output logic                   s_axi_bvalid_out,
  input  wire logic              s_axi_bready_in,
  // AXI4-Lite read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr_in,
  input  wire logic              s_axi_arvalid_in,
  output logic                   s_axi_arready_out,
  // AXI4-Lite read data
  output logic [31:0]            s_axi_rdata_out,
  output logic [1:0]             s_axi_rresp_out,
  output logic                   s_axi_rvalid_out,
  input  wire logic              s_axi_rready_in,
  // Status from PHY, PCS and auto-negotiation
  input  wire logic              wake_timer_done_in,
  input  wire logic              hw_eee_enabled_in,
  input  wire logic              tx_lpi_in,
  input  wire logic              rx_lpi_in,
  input  wire logic              pd_fault_in,
  input  wire logic              partner_np_able_in,
  input  wire logic              page_received_in,
  input  wire logic              partner_an_able_in,
  // Control outputs
  output logic [1:0]             rsvd_rw_out
);
  // Write channel: address and data are captured independently, in either order.
  logic              aw_have_q, aw_have_d;
  logic [ADDR_W-1:0] aw_addr_q, aw_addr_d;
  logic              w_have_q,  w_have_d;
  logic [31:0]       w_data_q,  w_data_d;
  logic [3:0]        w_strb_q,  w_strb_d;
  logic              bvalid_q,  bvalid_d;
  logic [1:0]        bresp_q,   bresp_d;
  logic              awready_q, awready_d;
  logic              wready_q,  wready_d;
  // Read channel.
  logic              arready_q, arready_d;
  logic              rvalid_q,  rvalid_d;
  logic [31:0]       rdata_q,   rdata_d;
  logic [1:0]        rresp_q,   rresp_d;
  // Status latches and software bits.
  logic              tx_lh_q, tx_lh_d;
  logic              rx_lh_q, rx_lh_d;
  logic              pdf_q,   pdf_d;
  logic              pgr_q,   pgr_d;
  logic              rsvd15_q, rsvd15_d;
  logic [1:0]        rsvd98_q, rsvd98_d;

  logic              wr_fire;
  logic              rd_fire;
  logic              rd_wec;
  logic              rd_cs;
  logic [15:0]       wec_count;
  logic [15:0]       cs_word;

  function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] r);
    addr_is = (a == r);
  endfunction : addr_is

  pesc_wake_counter u_wake
  (
    .mclk_in   (mclk_in),
    .rst_n_in  (rst_n_in),
    .done_in   (wake_timer_done_in),
    .clear_in  (rd_wec),
    .count_out (wec_count)
  );

  always_comb
  begin
    cs_word = '0;
    cs_word[BIT_RSVD15]     = rsvd15_q;
    cs_word[BIT_HW_EEE]     = hw_eee_enabled_in;
    cs_word[BIT_TX_LPI_LH]  = tx_lh_q;
    cs_word[BIT_TX_LPI]     = tx_lpi_in;
    cs_word[BIT_RX_LPI_LH]  = rx_lh_q;
    cs_word[BIT_RX_LPI]     = rx_lpi_in;
    cs_word[9:8]            = rsvd98_q;
    cs_word[BIT_NP_LOC_ABL] = 1'b1;
    cs_word[BIT_NP_LOC]     = 1'b1;
    cs_word[BIT_PD_FAULT]   = pdf_q;
    cs_word[BIT_LP_NP_ABL]  = partner_np_able_in;
    cs_word[BIT_NP_ABL]     = 1'b1;
    cs_word[BIT_PAGE_RX]    = pgr_q;
    cs_word[BIT_LP_AN_ABL]  = partner_an_able_in;
  end

  // Write path.
  always_comb
  begin
    aw_have_d = aw_have_q;
    aw_addr_d = aw_addr_q;
    w_have_d  = w_have_q;
    w_data_d  = w_data_q;
    w_strb_d  = w_strb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    if (s_axi_awvalid_in && awready_q)
    begin
      aw_have_d = 1'b1;
      aw_addr_d = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && wready_q)
    begin
      w_have_d = 1'b1;
      w_data_d = s_axi_wdata_in;
      w_strb_d = s_axi_wstrb_in;
    end
    wr_fire = aw_have_q && w_have_q && !bvalid_q;
    if (wr_fire)
    begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = (addr_is(aw_addr_q, WEC_ADDR) || addr_is(aw_addr_q, CS_ADDR)) ?
                  RESP_OKAY : RESP_SLVERR;
    end
    if (bvalid_q && s_axi_bready_in)
    begin
      bvalid_d = 1'b0;
    end
    awready_d = !aw_have_d && !bvalid_d;
    wready_d  = !w_have_d && !bvalid_d;
  end

  // Read path answers one cycle after the address is taken.
  // The counter clears in the take cycle, so a wake edge in that cycle is kept, not lost.
  always_comb
  begin
    arready_d = arready_q;
    rvalid_d  = rvalid_q;
    rdata_d   = rdata_q;
    rresp_d   = rresp_q;
    rd_fire   = s_axi_arvalid_in && arready_q;
    rd_wec    = rd_fire && addr_is(s_axi_araddr_in, WEC_ADDR);
    rd_cs     = rd_fire && addr_is(s_axi_araddr_in, CS_ADDR);
    if (rd_fire)
    begin
      arready_d = 1'b0;
      rvalid_d  = 1'b1;
      rresp_d   = RESP_OKAY;
      rdata_d   = '0;
      if (rd_wec)
      begin
        rdata_d[15:0] = wec_count;
      end
      else if (rd_cs)
      begin
        rdata_d[15:0] = cs_word;
      end
      else
      begin
        rresp_d = RESP_SLVERR;
      end
    end
    if (rvalid_q && s_axi_rready_in)
    begin
      rvalid_d  = 1'b0;
      arready_d = 1'b1;
    end
    // Ready rises whenever the slot is idle, which also covers the first cycle after reset.
    if (!rvalid_q && !rd_fire)
    begin
      arready_d = 1'b1;
    end
  end

  // Status latches: a new event in the clearing cycle keeps the bit set.
  always_comb
  begin
    logic cs_wr_hi;
    // The low byte holds no writable bit, so only the upper strobe matters here.
    cs_wr_hi = wr_fire && addr_is(aw_addr_q, CS_ADDR) && w_strb_q[1];
    rsvd15_d = rsvd15_q;
    rsvd98_d = rsvd98_q;
    if (cs_wr_hi)
    begin
      rsvd15_d = w_data_q[BIT_RSVD15];
      rsvd98_d = w_data_q[9:8];
    end
    tx_lh_d = (tx_lh_q && !(cs_wr_hi && w_data_q[BIT_TX_LPI_LH])) || tx_lpi_in;
    rx_lh_d = (rx_lh_q && !(cs_wr_hi && w_data_q[BIT_RX_LPI_LH])) || rx_lpi_in;
    pdf_d = (pdf_q && !rd_cs) || pd_fault_in;
    pgr_d = (pgr_q && !rd_cs) || page_received_in;
  end

  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      aw_have_q <= 1'b0;
      aw_addr_q <= '0;
      w_have_q  <= 1'b0;
      w_data_q  <= '0;
      w_strb_q  <= '0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= '0;
      rresp_q   <= RESP_OKAY;
      tx_lh_q   <= 1'b0;
      rx_lh_q   <= 1'b0;
      pdf_q     <= 1'b0;
      pgr_q     <= 1'b0;
      rsvd15_q  <= 1'b1;
      rsvd98_q  <= 2'h0;
    end
    else
    begin
      aw_have_q <= aw_have_d;
      aw_addr_q <= aw_addr_d;
      w_have_q  <= w_have_d;
      w_data_q  <= w_data_d;
      w_strb_q  <= w_strb_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      awready_q <= awready_d;
      wready_q  <= wready_d;
      arready_q <= arready_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
      tx_lh_q   <= tx_lh_d;
      rx_lh_q   <= rx_lh_d;
      pdf_q     <= pdf_d;
      pgr_q     <= pgr_d;
      rsvd15_q  <= rsvd15_d;
      rsvd98_q  <= rsvd98_d;
    end
  end

  assign s_axi_awready_out = awready_q;
  assign s_axi_wready_out  = wready_q;
  assign s_axi_bvalid_out  = bvalid_q;
  assign s_axi_bresp_out   = bresp_q;
  assign s_axi_arready_out = arready_q;
  assign s_axi_rvalid_out  = rvalid_q;
  assign s_axi_rdata_out   = rdata_q;
  assign s_axi_rresp_out   = rresp_q;
  assign rsvd_rw_out       = rsvd98_q;

  chk_txlh_holds : assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (tx_lh_q && !(wr_fire && addr_is(aw_addr_q, CS_ADDR) && w_strb_q[1])) |=> tx_lh_q)
    else $error("tx lpi latch dropped");
  chk_txlh_sets : assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    tx_lpi_in |=> tx_lh_q)
    else $error("tx lpi latch not set");
  chk_rxlh_sets : assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    rx_lpi_in |=> rx_lh_q)
    else $error("rx lpi latch not set");
  chk_pdf_clear : assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (rd_cs && !pd_fault_in) |=> !pdf_q)
    else $error("fault not cleared by read");
  chk_page_latch : assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    page_received_in |=> pgr_q)
    else $error("page latch not set");
  chk_page_clear : assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (rd_cs && !page_received_in) |=> !pgr_q)
    else $error("page latch not cleared by read");
  chk_wec_read : assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (rd_wec && !wake_timer_done_in) |=> wec_count == WEC_RESET)
    else $error("counter not cleared by read");
  chk_const_bits : assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    rd_cs |=> rdata_q[BIT_NP_LOC_ABL] && rdata_q[BIT_NP_LOC] && rdata_q[BIT_NP_ABL])
    else $error("constant bits wrong");
  chk_rvalid_time : assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    rd_fire |=> rvalid_q)
    else $error("read answer late");
  chk_rxlh_holds : assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (rx_lh_q && !(wr_fire && addr_is(aw_addr_q, CS_ADDR) && w_strb_q[1])) |=> rx_lh_q)
    else $error("rx lpi latch dropped");
  chk_pdf_sets : assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    pd_fault_in |=> pdf_q)
    else $error("fault latch not set");
  chk_bvalid_stands : assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (bvalid_q && !s_axi_bready_in) |=> bvalid_q)
    else $error("write response dropped early");
  chk_rvalid_stands : assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (rvalid_q && !s_axi_rready_in) |=> rvalid_q && $stable(rdata_q))
    else $error("read answer dropped or changed");
  chk_aw_single : assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    aw_have_q |-> !awready_q)
    else $error("second write address accepted");
  chk_ar_single : assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    rvalid_q |-> !arready_q)
    else $error("second read address accepted");
  cov_write : cover property (@(posedge mclk_in) disable iff (!rst_n_in) wr_fire);
  cov_read_cs : cover property (@(posedge mclk_in) disable iff (!rst_n_in) rd_cs);
  cov_read_wec : cover property (@(posedge mclk_in) disable iff (!rst_n_in) rd_wec);
  cov_sat : cover property (@(posedge mclk_in) disable iff (!rst_n_in) wec_count == WEC_SAT);
  cov_both_lh : cover property (@(posedge mclk_in) disable iff (!rst_n_in) tx_lh_q && rx_lh_q);
endmodule : pesc_regs

// File: rtl/pesc_wake_counter.sv
`timescale 1ns/1ps
module pesc_wake_counter
  import pesc_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk_in,
  input  wire logic        rst_n_in,
  // Event and clear
  input  wire logic        done_in,
  input  wire logic        clear_in,
  // Count
  output logic [15:0]      count_out
);
  logic        done_q;
  logic        done_d;
  logic [15:0] count_q;
  logic [15:0] count_d;
  logic        rise;

  always_comb
  begin
    done_d = done_in;
    rise = done_in & ~done_q;
    count_d = count_q;
    if (clear_in)
    begin
      count_d = WEC_RESET;
    end
    if (rise && (count_d != WEC_SAT))
    begin
      count_d = count_d + ONE16;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      done_q  <= 1'b0;
      count_q <= WEC_RESET;
    end
    else
    begin
      done_q  <= done_d;
      count_q <= count_d;
    end
  end

  assign count_out = count_q;

  chk_count_saturate : assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (count_q == WEC_SAT && !clear_in) |=> count_q == WEC_SAT)
    else $error("wake counter wrapped");
  chk_count_step : assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (rise && !clear_in && count_q != WEC_SAT) |=> count_q == $past(count_q) + ONE16)
    else $error("wake counter missed an edge");
endmodule : pesc_wake_counter

// File: test/pesc_phy_model.sv
`timescale 1ns/1ps
module pesc_phy_model
  import pesc_pkg::*;
(
  // Clock
  input  wire logic mclk_in,
  // Status towards the register block
  output logic      wake_timer_done_out,
  output logic      hw_eee_enabled_out,
  output logic      tx_lpi_out,
  output logic      rx_lpi_out,
  output logic      pd_fault_out,
  output logic      partner_np_able_out,
  output logic      page_received_out,
  output logic      partner_an_able_out
);
  initial
  begin
    wake_timer_done_out = 1'b0;
    hw_eee_enabled_out  = 1'b0;
    tx_lpi_out          = 1'b0;
    rx_lpi_out          = 1'b0;
    pd_fault_out        = 1'b0;
    partner_np_able_out = 1'b0;
    page_received_out   = 1'b0;
    partner_an_able_out = 1'b0;
  end

  // Slow wake-ups, each one a low-to-high edge.
  task automatic pulse_wake(input int n);
    repeat (n)
    begin
      @(posedge mclk_in);
      wake_timer_done_out <= 1'b1;
      @(posedge mclk_in);
      wake_timer_done_out <= 1'b0;
    end
  endtask : pulse_wake

  // The PCS shows LPI signalling as a level while it lasts.
  task automatic set_levels(input logic [4:0] v);
    @(posedge mclk_in);
    {hw_eee_enabled_out, tx_lpi_out, rx_lpi_out, partner_np_able_out,
     partner_an_able_out} <= v;
  endtask : set_levels

  // One-cycle fault and page events; the block must latch them.
  task automatic pulse_events();
    @(posedge mclk_in);
    pd_fault_out      <= 1'b1;
    page_received_out <= 1'b1;
    @(posedge mclk_in);
    pd_fault_out      <= 1'b0;
    page_received_out <= 1'b0;
  endtask : pulse_events
endmodule : pesc_phy_model

// File: test/tb_port_eee_status_counter_regs.sv
`timescale 1ns/1ps
module tb_port_eee_status_counter_regs
  import pesc_pkg::*;
;
  logic              mclk = 1'b0;
  logic              rst_n = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic              arvalid = 1'b0, rready = 1'b0;
  logic [31:0]       wdata = '0;
  logic [3:0]        wstrb = '0;
  logic              awready, wready, bvalid, arready, rvalid;
  logic [1:0]        bresp, rresp, rsvd_rw;
  logic [31:0]       rdata;
  logic              done, eee, txl, rxl, pdf, npa, pgr, ana;
  logic [31:0]       rd;
  logic [1:0]        rsp;
  int                mismatches = 0;
  int                n_checks = 0;
  // Status word with all inputs low: bit 15 and the fixed ones at 6, 5 and 2.
  localparam logic [31:0] CS_DEF = 32'h0000_8064;

  always #2.5 mclk = ~mclk;

  pesc_regs pesc_regs_i (
    .mclk_in(mclk), .rst_n_in(rst_n),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
    .wake_timer_done_in(done), .hw_eee_enabled_in(eee), .tx_lpi_in(txl),
    .rx_lpi_in(rxl), .pd_fault_in(pdf), .partner_np_able_in(npa),
    .page_received_in(pgr), .partner_an_able_in(ana), .rsvd_rw_out(rsvd_rw)
  );

  pesc_phy_model pesc_phy_model_i (
    .mclk_in(mclk), .wake_timer_done_out(done), .hw_eee_enabled_out(eee),
    .tx_lpi_out(txl), .rx_lpi_out(rxl), .pd_fault_out(pdf),
    .partner_np_able_out(npa), .page_received_out(pgr), .partner_an_able_out(ana)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic axi_write(input logic [ADDR_W-1:0] a, input logic [31:0] d,
                           input logic [3:0] s, output logic [1:0] r);
    @(posedge mclk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    r = bresp;
    bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [ADDR_W-1:0] a, output logic [31:0] d,
                          output logic [1:0] r);
    @(posedge mclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axi_read

  task automatic read_expect(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    axi_read(a, rd, rsp);
    check({30'h0, rsp}, {30'h0, RESP_OKAY});
    check(rd, exp);
  endtask : read_expect

  task automatic stop_test();
    if (mismatches == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : stop_test

  // The sequence needs well under a thousand cycles; this limit only catches a hang.
  initial
  begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    stop_test();
  end

  initial
  begin
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    read_expect(CS_ADDR, CS_DEF);
    read_expect(WEC_ADDR, 32'h0);
    pesc_phy_model_i.pulse_wake(3);
    read_expect(WEC_ADDR, 32'h3);
    read_expect(WEC_ADDR, 32'h0);
    // A host write must not disturb the count.
    pesc_phy_model_i.pulse_wake(2);
    axi_write(WEC_ADDR, 32'h0000_1234, 4'hF, rsp);
    check({30'h0, rsp}, {30'h0, RESP_OKAY});
    read_expect(WEC_ADDR, 32'h2);
    pesc_phy_model_i.set_levels(5'h1F);
    read_expect(CS_ADDR, 32'h0000_FC6D);
    pesc_phy_model_i.set_levels(5'h00);
    read_expect(CS_ADDR, 32'h0000_A864);
    axi_write(CS_ADDR, 32'h0000_A000, 4'h2, rsp);
    read_expect(CS_ADDR, 32'h0000_8864);
    axi_write(CS_ADDR, 32'h0000_8800, 4'h2, rsp);
    read_expect(CS_ADDR, CS_DEF);
    pesc_phy_model_i.pulse_events();
    read_expect(CS_ADDR, 32'h0000_8076);
    read_expect(CS_ADDR, CS_DEF);
    // Ones written to read-only bits must not stick; bits 15, 9 and 8 are writable.
    axi_write(CS_ADDR, 32'h0000_7FFF, 4'hF, rsp);
    read_expect(CS_ADDR, 32'h0000_0364);
    check({30'h0, rsvd_rw}, 32'h3);
    axi_write(14'h0004, 32'h0000_FFFF, 4'hF, rsp);
    check({30'h0, rsp}, {30'h0, RESP_SLVERR});
    axi_read(14'h0004, rd, rsp);
    check({30'h0, rsp}, {30'h0, RESP_SLVERR});
    check(rd, 32'h0);
    read_expect(CS_ADDR, 32'h0000_0364);
    stop_test();
  end
endmodule : tb_port_eee_status_counter_regs
